// File: async_rx_nine_bit_address_detect.sv
`timescale 1ns/1ns
`include "rx_addr_cfg.svh"
module async_rx_nine_bit_address_detect #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // Register port
  input  wire rx_addr_pkg::bus_req_type  busReq,
  output logic [7:0]                     rdData,
  // Serial line
  input  wire logic                      rxLine,
  // Interrupt
  output logic                           irq
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic                      portEnable_reg, nineBit_reg, singleRx_reg;
  logic                      contRx_reg, addrDet_reg, overrun_reg;
  logic [7:0]                baudDiv_reg;
  logic                      clockSrc_reg, nineTx_reg, transmit_en_reg;
  logic                      syncMode_reg, baudHigh_reg, txNinth_reg;
  logic                      globalEn_reg, periphGate_reg, rxIrqEn_reg;
  logic [2:0]                evtStatus_reg, evtEn_reg;
  logic [7:0]                rdData_reg, rdData_next;
  logic                      irq_reg;
  logic                      rxMeta_reg, rxSync_reg;
  logic [9:0]                baudCnt_reg;
  logic [2:0]                samp_reg;
  rx_addr_pkg::rx_state_type state_reg;
  logic [3:0]                phase_reg, bitCnt_reg;
  logic [8:0]                rxShift_reg;
  rx_addr_pkg::rx_char_type  fifoMem [DEPTH];
  logic [PW-1:0]             wrPtr_reg, rdPtr_reg;
  logic [PW:0]               count_reg;

  logic                      wrHit, rdHit;
  logic                      rxActive, tick, maj, filter;
  logic [9:0]                baudLimit;
  logic [3:0]                nBits;
  logic                      charDone, keep, push, pop, ovrSet;
  rx_addr_pkg::rx_char_type  charWord, head;
  logic                      rxReady;
  logic [2:0]                evtSet;

  assign rdData = rdData_reg;
  assign irq    = irq_reg;
  assign wrHit  = busReq.wr;
  assign rdHit  = busReq.rd;

  // Control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      portEnable_reg <= 1'b0;
      nineBit_reg    <= 1'b0;
      singleRx_reg   <= 1'b0;
      contRx_reg     <= 1'b0;
      addrDet_reg    <= 1'b0;
      baudDiv_reg    <= '0;
      clockSrc_reg   <= 1'b0;
      nineTx_reg     <= 1'b0;
      transmit_en_reg       <= 1'b0;
      syncMode_reg   <= 1'b0;
      baudHigh_reg   <= 1'b0;
      txNinth_reg    <= 1'b0;
      globalEn_reg   <= 1'b0;
      periphGate_reg <= 1'b0;
      rxIrqEn_reg    <= 1'b0;
      evtEn_reg      <= '0;
    end else if (wrHit) begin
      if (busReq.addr == `A_RXSTAT) begin
        portEnable_reg <= busReq.wrData[`B_PORT_EN];
        nineBit_reg    <= busReq.wrData[`B_NINE_RX];
        singleRx_reg   <= busReq.wrData[`B_SINGLE_RX];
        contRx_reg     <= busReq.wrData[`B_CONT_RX];
        addrDet_reg    <= busReq.wrData[`B_ADDR_DET];
      end else if (busReq.addr == `A_BAUD) begin
        baudDiv_reg <= busReq.wrData;
      end else if (busReq.addr == `A_TXSTAT) begin
        clockSrc_reg <= busReq.wrData[`B_CLK_SRC];
        nineTx_reg   <= busReq.wrData[`B_NINE_TX];
        transmit_en_reg     <= busReq.wrData[`B_TX_EN];
        syncMode_reg <= busReq.wrData[`B_SYNC_MODE];
        baudHigh_reg <= busReq.wrData[`B_BAUD_HIGH];
        txNinth_reg  <= busReq.wrData[`B_TX_NINTH];
      end else if (busReq.addr == `A_IRQCTL) begin
        globalEn_reg   <= busReq.wrData[`B_GLOBAL_EN];
        periphGate_reg <= busReq.wrData[`B_PERIPH_GATE];
      end else if (busReq.addr == `A_PIEN) begin
        rxIrqEn_reg <= busReq.wrData[`B_RX_IRQ];
      end else if (busReq.addr == `A_EVEN) begin
        evtEn_reg <= busReq.wrData[2:0];
      end
    end
  end

  // Synchronous mode is not built, so the receiver simply stays off with it set
  assign rxActive = portEnable_reg & contRx_reg & ~syncMode_reg & ~overrun_reg;
  assign filter   = addrDet_reg & nineBit_reg;

  // Line synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxMeta_reg <= 1'b1;
      rxSync_reg <= 1'b1;
    end else begin
      rxMeta_reg <= rxLine;
      rxSync_reg <= rxMeta_reg;
    end
  end

  // Oversampling tick: divisor+1 clocks at high speed, four times that otherwise
  assign baudLimit = baudHigh_reg ? {2'h0, baudDiv_reg} : {baudDiv_reg, `LOW_PRESCALE};
  assign tick      = (baudCnt_reg == baudLimit);

  always_ff @(posedge clock) begin
    if (!rst_n || !portEnable_reg) begin
      baudCnt_reg <= '0;
    end else if (tick) begin
      baudCnt_reg <= '0;
    end else begin
      baudCnt_reg <= baudCnt_reg + 10'h001;
    end
  end

  // Majority of the last three oversamples
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      samp_reg <= '1;
    end else if (tick) begin
      samp_reg <= {samp_reg[1:0], rxSync_reg};
    end
  end
  assign maj = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2]) | (samp_reg[1] & samp_reg[2]);

  assign nBits = nineBit_reg ? `BITS_NINE : `BITS_EIGHT;

  // Bit recovery
  always_ff @(posedge clock) begin
    if (!rst_n || !rxActive) begin
      state_reg   <= rx_addr_pkg::IDLE;
      phase_reg   <= '0;
      bitCnt_reg  <= '0;
      rxShift_reg <= '0;
    end else if (tick) begin
      case (state_reg)
        rx_addr_pkg::IDLE: begin
          phase_reg <= '0;
          if (!rxSync_reg) begin
            state_reg <= rx_addr_pkg::START;
          end
        end
        rx_addr_pkg::START: begin
          // A glitch that is gone by mid start bit is dropped silently
          if (phase_reg == `OVS_HALF) begin
            phase_reg  <= '0;
            bitCnt_reg <= '0;
            state_reg  <= maj ? rx_addr_pkg::IDLE : rx_addr_pkg::DATA;
          end else begin
            phase_reg <= phase_reg + 4'h1;
          end
        end
        rx_addr_pkg::DATA: begin
          if (phase_reg == `OVS_LAST) begin
            phase_reg   <= '0;
            rxShift_reg <= {maj, rxShift_reg[8:1]};
            bitCnt_reg  <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == nBits - 4'h1) begin
              state_reg <= rx_addr_pkg::STOP;
            end
          end else begin
            phase_reg <= phase_reg + 4'h1;
          end
        end
        rx_addr_pkg::STOP: begin
          if (phase_reg == `OVS_LAST) begin
            phase_reg <= '0;
            state_reg <= rx_addr_pkg::IDLE;
          end else begin
            phase_reg <= phase_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= rx_addr_pkg::IDLE;
        end
      endcase
    end
  end

  assign charDone          = tick & (state_reg == rx_addr_pkg::STOP) & (phase_reg == `OVS_LAST);
  assign charWord.data     = nineBit_reg ? rxShift_reg[7:0] : rxShift_reg[8:1];
  assign charWord.ninth    = nineBit_reg & rxShift_reg[8];
  assign charWord.frameErr = ~maj;

  // FIFO control
  assign keep   = charDone & ~(filter & ~charWord.ninth);
  assign pop    = rdHit & (busReq.addr == `A_RXDATA) & (count_reg != '0);
  assign push   = keep & ((count_reg != FULL) | pop);
  assign ovrSet = keep & (count_reg == FULL) & ~pop;
  assign head   = fifoMem[rdPtr_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      fifoMem[wrPtr_reg] <= charWord;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !portEnable_reg) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + PW'(1);
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + PW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (PW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end

  // Overrun only ends through continuous receive or port enable going low
  always_ff @(posedge clock) begin
    if (!rst_n || !portEnable_reg || !contRx_reg) begin
      overrun_reg <= 1'b0;
    end else if (ovrSet) begin
      overrun_reg <= 1'b1;
    end
  end

  assign rxReady = (count_reg != '0);

  // Sticky event status; a new event beats a clear in the same cycle
  always_comb begin
    evtSet           = '0;
    evtSet[`EVT_CHAR] = push;
    evtSet[`EVT_OVR]  = ovrSet;
    evtSet[`EVT_FRM]  = push & charWord.frameErr;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evtStatus_reg <= '0;
    end else if (wrHit && busReq.addr == `A_EVCLR) begin
      evtStatus_reg <= (evtStatus_reg & ~busReq.wrData[2:0]) | evtSet;
    end else begin
      evtStatus_reg <= evtStatus_reg | evtSet;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= globalEn_reg & ((rxReady & rxIrqEn_reg & periphGate_reg) | (|(evtStatus_reg & evtEn_reg)));
    end
  end

  // Read mux; status reads have no side effect, only a data read advances the FIFO
  always_comb begin
    rdData_next = '0;
    if (busReq.addr == `A_RXDATA) begin
      rdData_next = (count_reg != '0) ? head.data : '0;
    end else if (busReq.addr == `A_RXSTAT) begin
      rdData_next[`B_PORT_EN]   = portEnable_reg;
      rdData_next[`B_NINE_RX]   = nineBit_reg;
      rdData_next[`B_SINGLE_RX] = singleRx_reg;
      rdData_next[`B_CONT_RX]   = contRx_reg;
      rdData_next[`B_ADDR_DET]  = addrDet_reg;
      rdData_next[`B_FRAME_ERR] = rxReady & head.frameErr;
      rdData_next[`B_OVERRUN]   = overrun_reg;
      rdData_next[`B_RX_NINTH]  = rxReady & head.ninth;
    end else if (busReq.addr == `A_BAUD) begin
      rdData_next = baudDiv_reg;
    end else if (busReq.addr == `A_TXSTAT) begin
      rdData_next[`B_CLK_SRC]   = clockSrc_reg;
      rdData_next[`B_NINE_TX]   = nineTx_reg;
      rdData_next[`B_TX_EN]     = transmit_en_reg;
      rdData_next[`B_SYNC_MODE] = syncMode_reg;
      rdData_next[`B_BAUD_HIGH] = baudHigh_reg;
      rdData_next[`B_TX_EMPTY]  = `TX_EMPTY_VAL;
      rdData_next[`B_TX_NINTH]  = txNinth_reg;
    end else if (busReq.addr == `A_IRQCTL) begin
      rdData_next[`B_GLOBAL_EN]   = globalEn_reg;
      rdData_next[`B_PERIPH_GATE] = periphGate_reg;
    end else if (busReq.addr == `A_PIEN) begin
      rdData_next[`B_RX_IRQ] = rxIrqEn_reg;
    end else if (busReq.addr == `A_PFLAG) begin
      rdData_next[`B_RX_IRQ] = rxReady;
    end else if (busReq.addr == `A_EVST) begin
      rdData_next[2:0] = evtStatus_reg;
    end else if (busReq.addr == `A_EVEN) begin
      rdData_next[2:0] = evtEn_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdHit ? rdData_next : '0;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  nine_bits_a: assert property (charDone && nineBit_reg |-> bitCnt_reg == `BITS_NINE)
    else $error("nine-bit character not nine bits");
  ninth_read_a: assert property (rdHit && busReq.addr == `A_RXSTAT && rxReady
    |=> rdData[`B_RX_NINTH] == $past(head.ninth))
    else $error("ninth bit status wrong");
  addr_filter_a: assert property (filter && charDone && !charWord.ninth |=> $stable(count_reg) || $past(pop))
    else $error("address filter let data in");
  filter_ninth_a: assert property (push && filter |-> charWord.ninth)
    else $error("filtered char without ninth bit");
  ready_set_a: assert property (push |=> rxReady)
    else $error("ready flag not set");
  irq_gate_a: assert property (globalEn_reg && periphGate_reg && rxIrqEn_reg && rxReady |=> irq)
    else $error("receive interrupt missing");
  irq_global_a: assert property (irq |-> $past(globalEn_reg))
    else $error("interrupt without global enable");
  continuous_rx_en_clear_a: assert property ($fell(contRx_reg) |=> !overrun_reg ##1 !overrun_reg)
    else $error("overrun not cleared");
  overrun_set_a: assert property (ovrSet |=> overrun_reg && count_reg == FULL)
    else $error("overrun not flagged");
  overrun_block_a: assert property (overrun_reg |-> !push)
    else $error("char accepted during overrun");
  bit_rate_a: assert property (state_reg == rx_addr_pkg::DATA && tick && phase_reg != `OVS_LAST
    |=> $stable(bitCnt_reg))
    else $error("shift advanced mid bit");
  frame_err_a: assert property (push && count_reg == '0 && !pop
    |=> head.frameErr == !$past(maj))
    else $error("framing error not reported");
  empty_flag_a: assert property (rdHit && busReq.addr == `A_PFLAG && count_reg == '0
    |=> !rdData[`B_RX_IRQ])
    else $error("ready flag with empty fifo");
endmodule

// File: rx_addr_cfg.svh
`ifndef RX_ADDR_CFG_SVH
`define RX_ADDR_CFG_SVH
// Register addresses
`define A_RXDATA  4'h0
`define A_RXSTAT  4'h1
`define A_BAUD    4'h2
`define A_TXSTAT  4'h3
`define A_IRQCTL  4'h4
`define A_PIEN    4'h5
`define A_PFLAG   4'h6
`define A_EVST    4'h7
`define A_EVCLR   4'h8
`define A_EVEN    4'h9
// rx_status_control fields
`define B_PORT_EN     7
`define B_NINE_RX     6
`define B_SINGLE_RX   5
`define B_CONT_RX     4
`define B_ADDR_DET    3
`define B_FRAME_ERR   2
`define B_OVERRUN     1
`define B_RX_NINTH    0
// tx_status_control fields
`define B_CLK_SRC     7
`define B_NINE_TX     6
`define B_TX_EN       5
`define B_SYNC_MODE   4
`define B_BAUD_HIGH   2
`define B_TX_EMPTY    1
`define B_TX_NINTH    0
`define TX_EMPTY_VAL  1'b1
// Interrupt control, enable and flag fields
`define B_GLOBAL_EN   7
`define B_PERIPH_GATE 6
`define B_RX_IRQ      5
// Event status bits
`define EVT_CHAR      0
`define EVT_OVR       1
`define EVT_FRM       2
// Receive timing
`define OVS_HALF      4'h7
`define OVS_LAST      4'hf
`define BITS_EIGHT    4'h8
`define BITS_NINE     4'h9
`define LOW_PRESCALE  2'h3
`endif

// File: rx_addr_pkg.sv
package rx_addr_pkg;
  typedef struct packed {
    logic       ninth;
    logic       frameErr;
    logic [7:0] data;
  } rx_char_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } bus_req_type;
  typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_type;
endpackage

// File: rx_line_driver.sv
`timescale 1ns/1ns
module rx_line_driver #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic clock,
  // Serial line toward the receiver
  output logic      rxLine
);
  // Bit time in clocks; the bench changes it when it slows the baud rate
  int bitClks = BIT_CLKS;

  initial rxLine = 1'b1;

  task automatic hold(input logic level, input int clks);
    @(posedge clock);
    rxLine <= level;
    repeat (clks - 1) @(posedge clock);
  endtask

  // LSB first, one stop bit; a bad stop is kept short so that its tail
  // fails the receiver's start check instead of opening a new frame
  task automatic send(input logic [8:0] value, input logic nine, input logic badStop);
    int n;
    n = nine ? 9 : 8;
    hold(1'b0, bitClks);
    for (int i = 0; i < n; i++) begin
      hold(value[i], bitClks);
    end
    if (badStop) begin
      hold(1'b0, bitClks / 2 + 2);
    end
    hold(1'b1, bitClks * 2);
  endtask
endmodule

// File: async_rx_nine_bit_address_detect_tb.sv
`timescale 1ns/1ns
`include "rx_addr_cfg.svh"
module async_rx_nine_bit_address_detect_tb;
  localparam int LIMIT = 12000;
  logic                     clock;
  logic                     rst_n;
  rx_addr_pkg::bus_req_type busReq;
  logic [7:0]               rdData;
  logic                     rxLine;
  logic                     irq;
  int                       n_mismatch;
  int                       total_checks;
  int                       cycles = 0;

  async_rx_nine_bit_address_detect #(.DEPTH(2)) DUT (
    .clock  (clock),
    .rst_n  (rst_n),
    .busReq (busReq),
    .rdData (rdData),
    .rxLine (rxLine),
    .irq    (irq)
  );

  // Divisor 0 with high speed gives one tick per clock, 16 clocks per bit
  rx_line_driver #(.BIT_CLKS(16)) tx (
    .clock  (clock),
    .rxLine (rxLine)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    total_checks++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic wr_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clock);
    busReq <= '{addr: addr, wrData: data, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] addr, input logic [7:0] expected);
    @(posedge clock);
    busReq <= '{addr: addr, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1;
    check(rdData, expected);
  endtask

  // Interrupt output follows its cause one clock later
  task automatic irq_chk(input logic expected);
    repeat (2) @(posedge clock);
    #1;
    check({7'h00, irq}, {7'h00, expected});
  endtask

  initial begin
    rst_n = 1'b0;
    busReq = '0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;

    rd_chk(`A_TXSTAT, 8'h02);
    rd_chk(`A_RXSTAT, 8'h00);
    rd_chk(`A_BAUD, 8'h00);
    rd_chk(`A_RXDATA, 8'h00);
    wr_reg(`A_PFLAG, 8'hff);
    rd_chk(`A_PFLAG, 8'h00);
    wr_reg(4'hf, 8'hff);
    rd_chk(4'hf, 8'h00);
    $display("test reset done");

    wr_reg(`A_BAUD, 8'h00);
    wr_reg(`A_TXSTAT, 8'h04);
    wr_reg(`A_RXSTAT, 8'h80);
    wr_reg(`A_IRQCTL, 8'hc0);
    wr_reg(`A_PIEN, 8'h20);
    wr_reg(`A_RXSTAT, 8'hc0);
    wr_reg(`A_RXSTAT, 8'hd0);
    rd_chk(`A_TXSTAT, 8'h06);
    tx.send(9'h1a5, 1'b1, 1'b0);
    rd_chk(`A_RXSTAT, 8'hd1);
    rd_chk(`A_PFLAG, 8'h20);
    irq_chk(1'b1);
    rd_chk(`A_RXDATA, 8'ha5);
    rd_chk(`A_PFLAG, 8'h00);
    irq_chk(1'b0);
    tx.send(9'h03c, 1'b1, 1'b1);
    rd_chk(`A_RXSTAT, 8'hd4);
    rd_chk(`A_RXDATA, 8'h3c);
    rd_chk(`A_RXSTAT, 8'hd0);
    $display("test nine bit done");

    wr_reg(`A_RXSTAT, 8'hd8);
    tx.send(9'h055, 1'b1, 1'b0);
    rd_chk(`A_PFLAG, 8'h00);
    tx.send(9'h1c3, 1'b1, 1'b0);
    rd_chk(`A_RXSTAT, 8'hd9);
    rd_chk(`A_RXDATA, 8'hc3);
    wr_reg(`A_RXSTAT, 8'hd0);
    tx.send(9'h011, 1'b1, 1'b0);
    rd_chk(`A_RXSTAT, 8'hd0);
    rd_chk(`A_RXDATA, 8'h11);
    wr_reg(`A_RXSTAT, 8'hd8);
    tx.send(9'h022, 1'b1, 1'b0);
    rd_chk(`A_PFLAG, 8'h00);
    $display("test address detect done");

    wr_reg(`A_RXSTAT, 8'h90);
    tx.send(9'h001, 1'b0, 1'b0);
    tx.send(9'h002, 1'b0, 1'b0);
    tx.send(9'h003, 1'b0, 1'b0);
    rd_chk(`A_RXSTAT, 8'h92);
    wr_reg(`A_RXSTAT, 8'h80);
    rd_chk(`A_RXSTAT, 8'h80);
    rd_chk(`A_RXDATA, 8'h01);
    rd_chk(`A_RXDATA, 8'h02);
    rd_chk(`A_PFLAG, 8'h00);
    wr_reg(`A_RXSTAT, 8'h90);
    tx.send(9'h004, 1'b0, 1'b0);
    rd_chk(`A_RXDATA, 8'h04);
    $display("test overrun done");

    rd_chk(`A_EVST, 8'h07);
    wr_reg(`A_EVCLR, 8'h07);
    rd_chk(`A_EVST, 8'h00);
    rd_chk(`A_EVCLR, 8'h00);
    wr_reg(`A_PIEN, 8'h00);
    wr_reg(`A_IRQCTL, 8'h80);
    wr_reg(`A_EVEN, 8'h01);
    tx.send(9'h0e7, 1'b0, 1'b0);
    irq_chk(1'b1);
    rd_chk(`A_EVST, 8'h01);
    wr_reg(`A_EVCLR, 8'h01);
    irq_chk(1'b0);
    rd_chk(`A_PFLAG, 8'h20);
    wr_reg(`A_IRQCTL, 8'hc0);
    irq_chk(1'b0);
    wr_reg(`A_PIEN, 8'h20);
    irq_chk(1'b1);
    wr_reg(`A_IRQCTL, 8'h40);
    irq_chk(1'b0);
    rd_chk(`A_RXDATA, 8'he7);
    $display("test interrupts done");

    // Synchronous mode keeps the receiver idle; then low speed, 64 clocks per bit
    wr_reg(`A_TXSTAT, 8'h14);
    tx.send(9'h05a, 1'b0, 1'b0);
    rd_chk(`A_PFLAG, 8'h00);
    wr_reg(`A_TXSTAT, 8'he1);
    rd_chk(`A_TXSTAT, 8'he3);
    wr_reg(`A_RXSTAT, 8'hb0);
    rd_chk(`A_RXSTAT, 8'hb0);
    tx.bitClks = 64;
    tx.send(9'h0b6, 1'b0, 1'b0);
    rd_chk(`A_PFLAG, 8'h20);
    rd_chk(`A_RXDATA, 8'hb6);
    $display("test modes done");

    wr_reg(`A_IRQCTL, 8'hc0);
    tx.send(9'h0c5, 1'b0, 1'b0);
    irq_chk(1'b1);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    irq_chk(1'b0);
    rd_chk(`A_RXSTAT, 8'h00);
    rd_chk(`A_PFLAG, 8'h00);
    rd_chk(`A_TXSTAT, 8'h02);
    rd_chk(`A_RXDATA, 8'h00);
    $display("test mid reset done");
    stop_test();
  end
endmodule
